// ---- verilog/crd_defines.svh ----
// constants for the register datapath: field positions, reset values, limits
`ifndef CRD_DEFINES_SVH
`define CRD_DEFINES_SVH

// instruction word fields
`define CRD_F_MSB        17
`define CRD_F_LSB        12
`define CRD_U_MSB        11
`define CRD_M_MSB        11
`define CRD_M_LSB        6
`define CRD_K_MSB        5

// function codes of note
`define CRD_INDEX_LIMIT  6'h28
`define CRD_FMT2_CODE    6'h00

// bank selector: enable bit position
`define CRD_SR_EN_BIT    3

// control memory address of index register zero
`define CRD_INDEX_BASE   7'h00

// reset values
`define CRD_P_RESET      16'h0000
`define CRD_ACC_RESET    36'h0_0000_0000
`define CRD_ICR_RESET    3'h0
`define CRD_SR_RESET     5'h00

`endif

// ---- verilog/crd_pkg.sv ----
// types shared by the register datapath and its bench
package crd_pkg;

  // operation requests from the control sequencer
  typedef enum logic [4:0] {
    OP_NOP    = 5'h00, OP_FETCH = 5'h01, OP_IFETCH = 5'h02, OP_INDEX = 5'h03,
    OP_READ   = 5'h04, OP_LDAL  = 5'h05, OP_LDAU   = 5'h06, OP_ADD   = 5'h07,
    OP_MASK   = 5'h08, OP_MUL   = 5'h09, OP_DIV    = 5'h0A, OP_SHA   = 5'h0B,
    OP_SHAU   = 5'h0C, OP_SHAL  = 5'h0D, OP_CPA    = 5'h0E, OP_CPAU  = 5'h0F,
    OP_CPAL   = 5'h10, OP_SKIP  = 5'h11, OP_JUMP   = 5'h12, OP_RJ    = 5'h13,
    OP_SICR   = 5'h14, OP_SSR   = 5'h15, OP_STAL   = 5'h16, OP_LDA2  = 5'h17,
    OP_STA2   = 5'h18, OP_IOB   = 5'h19, OP_OUTE   = 5'h1A, OP_OUTO  = 5'h1B,
    OP_OUTP   = 5'h1C, OP_LDK   = 5'h1D
  } crd_op_e;

  // memory sequencing states, gray along idle-main-second-control-idle
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_MAIN  = 2'b01,
    S_MAIN2 = 2'b11,
    S_CTRL  = 2'b10
  } crd_state_e;

  // main memory request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
  } crd_mm_s;

  // control memory request
  typedef struct packed {
    logic       req;
    logic [6:0] addr;
  } crd_cm_s;

  // output holding registers with strobes
  typedef struct packed {
    logic [17:0] even;
    logic [17:0] odd;
    logic        evenStb;
    logic        oddStb;
    logic        paired;
  } crd_chan_s;

endpackage

// ---- verilog/crd_datapath.sv ----
// register datapath of an 18-bit one's complement processor
`include "crd_defines.svh"

// How it works
// - 36-bit accumulator takes full product and holds the dividend before divide.
// - upper half holds high bits, logical mask, and division remainder.
// - lower half is main accumulator; gets quotient and sums.
// - whole accumulator and each half shift and complement separately.
// - odd codes below 50 octal load index value and add it to operand.
// - indexed address keeps only the low bits that fit the address register.
// - index modifier also holds one buffer control word during I/O.
// - three-bit selector picks one of eight index registers in control memory.
// - program counter steps by one once an instruction is fetched.
// - satisfied skip steps the program counter once more.
// - return jump stores stepped counter at target, then enters the routine.
// - interrupt return jump stores unstepped counter since entry skips the step.
// - bank register bit 3 picks bank source; jump and return jump use counter bank.
// - even and odd output holding registers, pairable into one 36-bit word.
// - 7-bit function register: code in low six, top bit marks second format.
// - address register captured at cycle start and held; 16 main, 7 control.
// - main and control transfers each pass through their own 18-bit buffer.
// - double word: higher address holds upper half, lower address lower half.
// - 12-bit constant sign extended by copying bit 11 into six upper bits.
// - first format: code in high six bits, operand in low twelve.
// - second format: six-bit minor code and six-bit designator.
// - arithmetic works on 18-bit one's complement integers.
module crd_datapath
  import crd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // operation request
  input  wire logic        opValid,
  input  crd_op_e          opCode,
  input  wire logic [17:0] opData,
  output logic             busy,
  // main memory
  output crd_mm_s          mmOut,
  output logic [17:0]      mmWdata,
  input  wire logic [17:0] mmRdata,
  input  wire logic        mmAck,
  // control memory
  output crd_cm_s          cmOut,
  input  wire logic [17:0] cmRdata,
  input  wire logic        cmAck,
  // output channels
  output crd_chan_s        chanOut,
  // visible state
  output logic [35:0]      accOut,
  output logic [15:0]      progCounter,
  output logic [17:0]      indexModifier,
  output logic [2:0]       indexSelector,
  output logic [4:0]       memoryBankSelector,
  output logic [6:0]       functionCode,
  output logic [17:0]      designatorWord
);

  crd_state_e  state_q;
  crd_state_e  state_d;
  crd_op_e     op_q;
  crd_mm_s     mainMemoryAddress_q;
  crd_cm_s     controlMemoryAddress_q;
  crd_chan_s   chan_q;
  logic [17:0] mainMemoryBuffer_q;
  logic [17:0] controlMemoryBuffer_q;
  logic [17:0] upperAccumulatorHalf_q;
  logic [17:0] lowerAccumulatorHalf_q;
  logic [17:0] indexModifier_q;
  logic [2:0]  indexSelector_q;
  logic [4:0]  memoryBankSelector_q;
  logic [15:0] programCounter_q;
  logic [17:0] instr_q;
  logic [6:0]  function_q;
  logic [17:0] operand_q;
  logic        busy_q;

  logic        accept;
  logic        startMain;
  logic        startCtrl;
  logic        indexQual;
  logic        twoWord;
  logic        mainDone;
  logic        main2Done;
  logic        ctrlDone;
  logic        usePBank;
  logic [3:0]  bank;
  logic [17:0] yWord;
  logic [15:0] effAddr;
  logic [17:0] constWord;
  logic [35:0] product;
  logic [35:0] dividendMag;
  logic [35:0] quotientMag;
  logic [35:0] remainderMag;
  logic [17:0] divisorMag;
  logic        divSign;

  // one's complement add with end-around carry
  function automatic logic [17:0] onesAdd(input logic [17:0] a, input logic [17:0] b);
    logic [18:0] s;
    s = {1'b0, a} + {1'b0, b};
    onesAdd = s[17:0] + {17'h0_0000, s[18]};
  endfunction

  // right shifts copy the sign, left shifts rotate so one's complement values survive
  function automatic logic [35:0] shift36(input logic [35:0] x, input logic [6:0] c);
    int k;
    k = int'(c[5:0]) % 36;
    if (c[6])
      shift36 = (x << k) | (x >> (36 - k));
    else
      shift36 = 36'($signed(x) >>> k);
  endfunction

  function automatic logic [17:0] shift18(input logic [17:0] x, input logic [6:0] c);
    int k;
    k = int'(c[5:0]) % 18;
    if (c[6])
      shift18 = (x << k) | (x >> (18 - k));
    else
      shift18 = 18'($signed(x) >>> k);
  endfunction

  // request decode
  always_comb
  begin
    accept    = opValid && (state_q == S_IDLE);
    indexQual = instr_q[`CRD_F_LSB] && (instr_q[`CRD_F_MSB:`CRD_F_LSB] < `CRD_INDEX_LIMIT);
    startMain = accept && (opCode inside {OP_FETCH, OP_IFETCH, OP_READ, OP_STAL, OP_RJ,
                                          OP_LDA2, OP_STA2});
    startCtrl = accept && ((opCode == OP_INDEX && indexQual) || opCode == OP_IOB);
    twoWord   = op_q inside {OP_LDA2, OP_STA2};
    mainDone  = (state_q == S_MAIN) && mmAck;
    main2Done = (state_q == S_MAIN2) && mmAck;
    ctrlDone  = (state_q == S_CTRL) && cmAck;
  end

  // operand address: bank extension, index add, truncation
  always_comb
  begin
    usePBank  = (opCode inside {OP_JUMP, OP_RJ}) ||
                !memoryBankSelector_q[`CRD_SR_EN_BIT];
    bank      = usePBank ? programCounter_q[15:12]
                         : {memoryBankSelector_q[4], memoryBankSelector_q[2:0]};
    yWord     = {2'b00, bank, instr_q[`CRD_U_MSB:0]};
    effAddr   = 16'(onesAdd(yWord, indexModifier_q));
    constWord = {{6{instr_q[`CRD_U_MSB]}}, instr_q[`CRD_U_MSB:0]};
  end

  // multiply and divide on sign-magnitude views of one's complement words
  always_comb
  begin
    product      = 36'(lowerAccumulatorHalf_q[17] ? ~lowerAccumulatorHalf_q
                                                  : lowerAccumulatorHalf_q) *
                   36'(operand_q[17] ? ~operand_q : operand_q);
    if (lowerAccumulatorHalf_q[17] ^ operand_q[17])
      product = ~product;
    dividendMag  = upperAccumulatorHalf_q[17] ? ~{upperAccumulatorHalf_q, lowerAccumulatorHalf_q}
                                              : {upperAccumulatorHalf_q, lowerAccumulatorHalf_q};
    divisorMag   = operand_q[17] ? ~operand_q : operand_q;
    divSign      = upperAccumulatorHalf_q[17] ^ operand_q[17];
    quotientMag  = '0;
    remainderMag = '0;
    if (divisorMag != 18'h0_0000)
    begin
      quotientMag  = dividendMag / {18'h0_0000, divisorMag};
      remainderMag = dividendMag % {18'h0_0000, divisorMag};
    end
  end

  // sequencing state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:
      begin
        if (startMain)
          state_d = S_MAIN;
        else if (startCtrl)
          state_d = S_CTRL;
      end
      S_MAIN:
        if (mmAck)
          state_d = twoWord ? S_MAIN2 : S_IDLE;
      S_MAIN2:
        if (mmAck)
          state_d = S_IDLE;
      S_CTRL:
        if (cmAck)
          state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= S_IDLE;
      busy_q  <= 1'b0;
      op_q    <= OP_NOP;
    end
    else
    begin
      state_q <= state_d;
      busy_q  <= (state_d != S_IDLE);
      if (accept)
        op_q <= opCode;
    end
  end

  // main memory address, captured at cycle start and held to the ack
  always_ff @(posedge clk)
  begin
    if (reset)
      mainMemoryAddress_q <= '0;
    else if (startMain)
    begin
      mainMemoryAddress_q.req  <= 1'b1;
      mainMemoryAddress_q.we   <= opCode inside {OP_STAL, OP_RJ, OP_STA2};
      mainMemoryAddress_q.addr <= (opCode == OP_FETCH)  ? programCounter_q :
                                  (opCode == OP_IFETCH) ? opData[15:0] : effAddr;
    end
    else if (mainDone && twoWord)
      mainMemoryAddress_q.addr <= mainMemoryAddress_q.addr + 16'h0001;
    else if (mainDone || main2Done)
      mainMemoryAddress_q.req <= 1'b0;
  end

  // main memory buffer: write data staged here, read data lands here
  always_ff @(posedge clk)
  begin
    if (reset)
      mainMemoryBuffer_q <= '0;
    else if (startMain && opCode == OP_RJ)
      mainMemoryBuffer_q <= {2'b00, programCounter_q};
    else if (startMain)
      mainMemoryBuffer_q <= lowerAccumulatorHalf_q;
    else if (mainDone && op_q == OP_STA2)
      mainMemoryBuffer_q <= upperAccumulatorHalf_q;
    else if ((mainDone || main2Done) && !mainMemoryAddress_q.we)
      mainMemoryBuffer_q <= mmRdata;
  end

  // control memory address and buffer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      controlMemoryAddress_q <= '0;
      controlMemoryBuffer_q  <= '0;
    end
    else if (startCtrl)
    begin
      controlMemoryAddress_q.req  <= 1'b1;
      controlMemoryAddress_q.addr <= (opCode == OP_IOB) ? opData[6:0]
                                     : `CRD_INDEX_BASE + {4'h0, indexSelector_q};
    end
    else if (ctrlDone)
    begin
      controlMemoryAddress_q.req <= 1'b0;
      controlMemoryBuffer_q      <= cmRdata;
    end
  end

  // index modifier: index value or a buffer control word
  always_ff @(posedge clk)
  begin
    if (reset)
      indexModifier_q <= '0;
    else if (accept && opCode == OP_INDEX && !indexQual)
      indexModifier_q <= '0; // unindexed codes must not disturb the address
    else if (ctrlDone)
      indexModifier_q <= cmRdata;
  end

  // selectors written by the program
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      indexSelector_q      <= `CRD_ICR_RESET;
      memoryBankSelector_q <= `CRD_SR_RESET;
    end
    else if (accept && opCode == OP_SICR)
      indexSelector_q <= opData[2:0];
    else if (accept && opCode == OP_SSR)
      memoryBankSelector_q <= opData[4:0];
  end

  // program counter; interrupt fetch leaves it unstepped
  always_ff @(posedge clk)
  begin
    if (reset)
      programCounter_q <= `CRD_P_RESET;
    else if (mainDone && op_q == OP_FETCH)
      programCounter_q <= programCounter_q + 16'h0001;
    else if (accept && opCode == OP_SKIP && opData[0])
      programCounter_q <= programCounter_q + 16'h0001;
    else if (accept && opCode == OP_JUMP)
      programCounter_q <= effAddr;
    else if (mainDone && op_q == OP_RJ)
      programCounter_q <= mainMemoryAddress_q.addr + 16'h0001;
  end

  // instruction and function register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      instr_q    <= '0;
      function_q <= '0;
    end
    else if (mainDone && op_q inside {OP_FETCH, OP_IFETCH})
    begin
      instr_q <= mmRdata;
      if (mmRdata[`CRD_F_MSB:`CRD_F_LSB] == `CRD_FMT2_CODE)
        function_q <= {1'b1, mmRdata[`CRD_M_MSB:`CRD_M_LSB]};
      else
        function_q <= {1'b0, mmRdata[`CRD_F_MSB:`CRD_F_LSB]};
    end
  end

  // arithmetic operand register
  always_ff @(posedge clk)
  begin
    if (reset)
      operand_q <= '0;
    else if (mainDone && op_q == OP_READ)
      operand_q <= mmRdata;
  end

  // accumulator halves
  always_ff @(posedge clk)
  begin
    if (reset)
      {upperAccumulatorHalf_q, lowerAccumulatorHalf_q} <= `CRD_ACC_RESET;
    else if (mainDone && op_q == OP_LDA2)
      lowerAccumulatorHalf_q <= mmRdata;
    else if (main2Done && op_q == OP_LDA2)
      upperAccumulatorHalf_q <= mmRdata;
    else if (accept)
    begin
      unique case (opCode)
        OP_LDAL: lowerAccumulatorHalf_q <= operand_q;
        OP_LDAU: upperAccumulatorHalf_q <= operand_q;
        OP_LDK:  lowerAccumulatorHalf_q <= onesAdd(constWord, indexModifier_q);
        OP_ADD:  lowerAccumulatorHalf_q <= onesAdd(lowerAccumulatorHalf_q, operand_q);
        OP_MASK: lowerAccumulatorHalf_q <= operand_q & upperAccumulatorHalf_q;
        OP_MUL:  {upperAccumulatorHalf_q, lowerAccumulatorHalf_q} <= product;
        OP_DIV:
        begin
          // divide by zero leaves the dividend untouched
          if (divisorMag != 18'h0_0000)
          begin
            lowerAccumulatorHalf_q <= divSign ? ~quotientMag[17:0] : quotientMag[17:0];
            upperAccumulatorHalf_q <= upperAccumulatorHalf_q[17] ? ~remainderMag[17:0]
                                                                 : remainderMag[17:0];
          end
        end
        OP_SHA:
          {upperAccumulatorHalf_q, lowerAccumulatorHalf_q} <=
            shift36({upperAccumulatorHalf_q, lowerAccumulatorHalf_q}, opData[6:0]);
        OP_SHAU: upperAccumulatorHalf_q <= shift18(upperAccumulatorHalf_q, opData[6:0]);
        OP_SHAL: lowerAccumulatorHalf_q <= shift18(lowerAccumulatorHalf_q, opData[6:0]);
        OP_CPA:
          {upperAccumulatorHalf_q, lowerAccumulatorHalf_q} <=
            ~{upperAccumulatorHalf_q, lowerAccumulatorHalf_q};
        OP_CPAU: upperAccumulatorHalf_q <= ~upperAccumulatorHalf_q;
        OP_CPAL: lowerAccumulatorHalf_q <= ~lowerAccumulatorHalf_q;
        default: ; // other requests leave the accumulator alone
      endcase
    end
  end

  // output holding registers; paired load puts the upper half on the odd channel
  always_ff @(posedge clk)
  begin
    if (reset)
      chan_q <= '0;
    else
    begin
      chan_q.evenStb <= accept && (opCode inside {OP_OUTE, OP_OUTP});
      chan_q.oddStb  <= accept && (opCode inside {OP_OUTO, OP_OUTP});
      chan_q.paired  <= accept && (opCode == OP_OUTP);
      if (accept && opCode inside {OP_OUTE, OP_OUTP})
        chan_q.even <= lowerAccumulatorHalf_q;
      if (accept && opCode == OP_OUTO)
        chan_q.odd <= lowerAccumulatorHalf_q;
      else if (accept && opCode == OP_OUTP)
        chan_q.odd <= upperAccumulatorHalf_q;
    end
  end

  // all outputs come straight from flops
  assign busy               = busy_q;
  assign mmOut              = mainMemoryAddress_q;
  assign mmWdata            = mainMemoryBuffer_q;
  assign cmOut              = controlMemoryAddress_q;
  assign chanOut            = chan_q;
  assign accOut             = {upperAccumulatorHalf_q, lowerAccumulatorHalf_q};
  assign progCounter        = programCounter_q;
  assign indexModifier      = indexModifier_q;
  assign indexSelector      = indexSelector_q;
  assign memoryBankSelector = memoryBankSelector_q;
  assign functionCode       = function_q;
  assign designatorWord     = controlMemoryBuffer_q;

endmodule

// ---- testbench/crd_mem_model.sv ----
// behavioural main and control memory facing the register datapath
module crd_mem_model
  import crd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // cycles of wait before each acknowledge
  input  wire logic [1:0]  ackDelay,
  // main memory side
  input  crd_mm_s          mmOut,
  input  wire logic [17:0] mmWdata,
  output logic [17:0]      mmRdata,
  output logic             mmAck,
  // control memory side
  input  crd_cm_s          cmOut,
  output logic [17:0]      cmRdata,
  output logic             cmAck
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [17:0] mainMem [0:65535];
  logic [17:0] ctrlMem [0:127];
  logic [1:0]  mmWait;
  logic [1:0]  cmWait;

  // one ack per access; data lines toggle outside the ack cycle so stale values never match
  always @(posedge clk)
  begin
    mmAck <= 1'b0;
    mmRdata <= reset ? 18'h2AAAA : ~mmRdata;
    if (reset || mmAck || !mmOut.req)
      mmWait <= 2'h0;
    else if (mmWait < ackDelay)
      mmWait <= mmWait + 2'h1;
    else
    begin
      mmAck <= 1'b1;
      if (mmOut.we)
        mainMem[mmOut.addr] <= mmWdata;
      else
        mmRdata <= mainMem[mmOut.addr];
    end
  end

  // control memory is read only from this side
  always @(posedge clk)
  begin
    cmAck <= 1'b0;
    cmRdata <= reset ? 18'h15555 : ~cmRdata;
    if (reset || cmAck || !cmOut.req)
      cmWait <= 2'h0;
    else if (cmWait < ackDelay)
      cmWait <= cmWait + 2'h1;
    else
    begin
      cmAck <= 1'b1;
      cmRdata <= ctrlMem[cmOut.addr];
    end
  end
endmodule

// ---- testbench/crd_datapath_checker.sv ----
// concurrent checks on the register datapath ports
`include "crd_defines.svh"
module crd_datapath_checker
  import crd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // request port
  input  wire logic        opValid,
  input  crd_op_e          opCode,
  input  wire logic [17:0] opData,
  input  wire logic        busy,
  // memories
  input  crd_mm_s          mmOut,
  input  wire logic [17:0] mmWdata,
  input  wire logic [17:0] mmRdata,
  input  wire logic        mmAck,
  input  crd_cm_s          cmOut,
  input  wire logic [17:0] cmRdata,
  input  wire logic        cmAck,
  // visible state
  input  crd_chan_s        chanOut,
  input  wire logic [35:0] accOut,
  input  wire logic [15:0] progCounter,
  input  wire logic [17:0] indexModifier,
  input  wire logic [2:0]  indexSelector,
  input  wire logic [6:0]  functionCode,
  input  wire logic [17:0] designatorWord
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic        take;
  logic        qual;
  logic        fetchPend_q;
  logic [15:0] fetchPc_q;
  assign take = opValid && !busy;
  // odd first-format code below the index limit asks for a modifier
  assign qual = !functionCode[6] && functionCode[0] && functionCode[5:0] < `CRD_INDEX_LIMIT;

  // remember a pending fetch and the counter it started from
  always_ff @(posedge clk)
  begin
    if (reset || (mmOut.req && mmAck))
      fetchPend_q <= 1'b0;
    else if (take && opCode == OP_FETCH)
      fetchPend_q <= 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (take && opCode == OP_FETCH)
      fetchPc_q <= progCounter;
  end

  sequence mm_done_s;
    mmOut.req && mmAck;
  endsequence
  sequence cm_done_s;
    cmOut.req && cmAck;
  endsequence
  sequence pair_pulse_s;
    chanOut.paired && chanOut.even == $past(accOut[17:0]) && chanOut.odd == $past(accOut[35:18])
      ##1 !chanOut.paired;
  endsequence

  reset_clear_a: assert property (
    $fell(reset) |-> accOut == 36'h0 && indexSelector == 3'h0 && progCounter == 16'h0)
    else $error("state not cleared by reset");
  fetch_step_a: assert property (
    fetchPend_q ##0 mm_done_s |=> progCounter == fetchPc_q + 16'h1)
    else $error("counter not stepped after fetch");
  skip_step_a: assert property (
    take && opCode == OP_SKIP |=> progCounter == $past(progCounter) + {15'h0, $past(opData[0])})
    else $error("skip step wrong");
  selector_load_a: assert property (
    take && opCode == OP_SICR |=> indexSelector == $past(opData[2:0]))
    else $error("index selector not loaded");
  mm_hold_a: assert property (
    mmOut.req && !mmAck |=> mmOut.req && $stable(mmOut.addr) && $stable(mmOut.we))
    else $error("main address moved mid access");
  cm_hold_a: assert property (
    cmOut.req && !cmAck |=> cmOut.req && $stable(cmOut.addr))
    else $error("control address moved mid access");
  mm_buffer_a: assert property (
    mm_done_s ##0 !mmOut.we |=> mmWdata == $past(mmRdata))
    else $error("main buffer missed read data");
  cm_buffer_a: assert property (
    cm_done_s |=> designatorWord == $past(cmRdata))
    else $error("control buffer missed read data");
  index_addr_a: assert property (
    take && opCode == OP_INDEX && qual
      |=> cmOut.req && cmOut.addr == `CRD_INDEX_BASE + {4'h0, $past(indexSelector)})
    else $error("index read at wrong place");
  pair_out_a: assert property (
    take && opCode == OP_OUTP |=> pair_pulse_s)
    else $error("paired output wrong");
  compl_all_a: assert property (
    take && opCode == OP_CPA |=> accOut == ~$past(accOut))
    else $error("accumulator not complemented");
  read_busy_a: assert property (
    take && opCode == OP_READ |=> busy && mmOut.req && !mmOut.we ##[1:40] !busy)
    else $error("read access not started or not ended");
endmodule

bind crd_datapath crd_datapath_checker chk_u (
  .clk(clk), .reset(reset), .opValid(opValid), .opCode(opCode), .opData(opData), .busy(busy),
  .mmOut(mmOut), .mmWdata(mmWdata), .mmRdata(mmRdata), .mmAck(mmAck), .cmOut(cmOut),
  .cmRdata(cmRdata), .cmAck(cmAck), .chanOut(chanOut), .accOut(accOut),
  .progCounter(progCounter), .indexModifier(indexModifier), .indexSelector(indexSelector),
  .functionCode(functionCode), .designatorWord(designatorWord)
);

// ---- testbench/tb.sv ----
// self-checking bench for the register datapath
`include "crd_defines.svh"
module tb
  import crd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, reset, opValid, busy, mmAck, cmAck;
  crd_op_e     opCode;
  logic [17:0] opData, mmWdata, mmRdata, cmRdata, indexModifier, designatorWord, w, v, nv;
  logic [1:0]  ackDelay;
  crd_mm_s     mmOut;
  crd_cm_s     cmOut;
  crd_chan_s   chanOut;
  logic [35:0] accOut;
  logic [15:0] progCounter, y, p;
  logic [2:0]  indexSelector;
  logic [4:0]  memoryBankSelector;
  logic [6:0]  functionCode;
  logic [5:0]  codes [4] = '{6'h01, 6'h27, 6'h29, 6'h02};
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;

  crd_datapath dut_u (
    .clk(clk), .reset(reset), .opValid(opValid), .opCode(opCode), .opData(opData),
    .busy(busy), .mmOut(mmOut), .mmWdata(mmWdata), .mmRdata(mmRdata), .mmAck(mmAck),
    .cmOut(cmOut), .cmRdata(cmRdata), .cmAck(cmAck), .chanOut(chanOut), .accOut(accOut),
    .progCounter(progCounter), .indexModifier(indexModifier), .indexSelector(indexSelector),
    .memoryBankSelector(memoryBankSelector), .functionCode(functionCode),
    .designatorWord(designatorWord));
  crd_mem_model mem_u (
    .clk(clk), .reset(reset), .ackDelay(ackDelay), .mmOut(mmOut), .mmWdata(mmWdata),
    .mmRdata(mmRdata), .mmAck(mmAck), .cmOut(cmOut), .cmRdata(cmRdata), .cmAck(cmAck));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard, far above the run's length
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      results();
    end
  end

  task automatic chk(input logic [36:0] seen, input logic [36:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one request at the falling edge, then wait out any memory access
  task automatic op(input crd_op_e c, input logic [17:0] d);
    int n;
    @(negedge clk);
    ackDelay = 2'($urandom_range(0, 3));
    opValid = 1'b1;
    opCode = c;
    opData = d;
    @(negedge clk);
    opValid = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic fetch(input logic [17:0] word);
    mem_u.mainMem[progCounter] = word;
    p = progCounter;
    op(OP_FETCH, 18'h0);
    chk(progCounter, p + 16'h1, "step");
    chk(mmWdata, word, "fetch buffer");
  endtask

  // second-format words carry the minor code with the top bit set
  function automatic logic [6:0] fexp(input logic [17:0] x);
    return (x[17:12] == `CRD_FMT2_CODE) ? {1'b1, x[11:6]} : {1'b0, x[17:12]};
  endfunction

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial
  begin
    reset = 1'b1;
    opValid = 1'b0;
    opCode = OP_NOP;
    opData = 18'h0;
    ackDelay = 2'h0;
    void'($urandom(46));
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk(accOut, 36'h0, "acc reset");
    chk({indexSelector, memoryBankSelector}, 8'h0, "selector reset");
    repeat (8)
    begin
      v = 18'($urandom);
      op(OP_SICR, v);
      chk(indexSelector, v[2:0], "selector");
      op(OP_SSR, v);
      chk(memoryBankSelector, v[4:0], "bank");
    end
    // both formats, extreme codes first
    for (int i = 0; i < 20; i++)
    begin
      w = (i < 2) ? {(i == 0) ? 6'h00 : 6'h3F, 12'($urandom)} : 18'($urandom);
      fetch(w);
      chk(functionCode, fexp(w), "function");
    end
    p = progCounter;
    op(OP_SKIP, 18'h1);
    chk(progCounter, p + 16'h1, "skip taken");
    op(OP_SKIP, 18'h0);
    chk(progCounter, p + 16'h1, "skip not taken");
    // qualified and unqualified codes; the last two leave the modifier at zero
    foreach (codes[i])
    begin
      v = 18'($urandom);
      op(OP_SICR, 18'(i));
      mem_u.ctrlMem[`CRD_INDEX_BASE + 7'(i)] = v;
      fetch({codes[i], 12'h0});
      op(OP_INDEX, 18'h0);
      chk(indexModifier, (i < 2) ? v : 18'h0, "index");
    end
    // bank extension, double word order, complements, paired output
    for (int i = 0; i < 6; i++)
    begin
      v = 18'($urandom);
      nv = ~v;
      w = {6'h02, 12'($urandom)};
      op(OP_SSR, v);
      fetch(w);
      y = v[`CRD_SR_EN_BIT] ? {v[4], v[2:0], w[11:0]} : {progCounter[15:12], w[11:0]};
      mem_u.mainMem[y] = nv;
      mem_u.mainMem[y + 16'h1] = v;
      op(OP_READ, 18'h0);
      op(OP_LDAL, 18'h0);
      chk(accOut[17:0], nv, "bank load");
      op(OP_LDA2, 18'h0);
      chk(accOut, {v, nv}, "double word");
      op(OP_CPAU, 18'h0);
      chk(accOut, {nv, nv}, "complement upper");
      op(OP_CPA, 18'h0);
      chk(accOut, {v, v}, "complement all");
      op(OP_CPAL, 18'h0);
      chk(accOut, {v, nv}, "complement lower");
      op(OP_OUTP, 18'h0);
      chk({chanOut.paired, chanOut.even, chanOut.odd}, {1'b1, nv, v}, "pair");
      op(OP_MASK, 18'h0);
      chk(accOut, {v, 18'h0}, "mask");
      op(OP_ADD, 18'h0);
      chk(accOut[17:0], nv, "add");
    end
    op(OP_SSR, 18'h0);
    // constants with sign corners
    for (int i = 0; i < 4; i++)
    begin
      w = {6'h02, (i == 0) ? 12'h800 : (i == 1) ? 12'h7FF : 12'($urandom)};
      fetch(w);
      op(OP_LDK, 18'h0);
      chk(accOut[17:0], {{6{w[11]}}, w[11:0]}, "constant");
    end
    // programmed return jump
    w = {6'h02, 12'($urandom)};
    fetch(w);
    p = progCounter;
    y = {p[15:12], w[11:0]};
    op(OP_RJ, 18'h0);
    chk(mem_u.mainMem[y], p, "link stored");
    chk(progCounter, y + 16'h1, "entry");
    // interrupt entry fetches without stepping
    w = {6'h02, 12'($urandom)};
    mem_u.mainMem[16'h0040] = w;
    p = progCounter;
    op(OP_IFETCH, 18'h00040);
    chk(progCounter, p, "no step");
    op(OP_RJ, 18'h0);
    chk(mem_u.mainMem[{p[15:12], w[11:0]}], p, "interrupt link");
    // control word through the modifier
    v = 18'($urandom);
    mem_u.ctrlMem[7'h55] = v;
    op(OP_IOB, 18'h55);
    chk(indexModifier, v, "control word");
    results();
  end
endmodule
